// ### xds_pkg.sv
// Shared constants and carrier types for the external data address select
// block: register offsets, field positions, reset values and timing counts.
// Assumes the core's special function register port is 8 bits wide with an
// 8-bit register address, and that external data addresses are 16 bits.
package xds_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int SFR_W  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Special function register addresses.
  localparam logic [SFR_W-1:0] PTR_SEL_ADDR  = 8'h86;
  localparam logic [SFR_W-1:0] PTR_LOW_ADDR  = 8'h82;
  localparam logic [SFR_W-1:0] PTR_HIGH_ADDR = 8'h83;
  localparam logic [SFR_W-1:0] CLK_CTRL_ADDR = 8'h8E;

  // Field positions and reset values.
  localparam int               PTR_SEL_BIT    = 0;
  localparam int               STRETCH_LSB    = 0;
  localparam int               STRETCH_W      = 3;
  localparam logic [2:0]       STRETCH_RESET  = 3'h1;
  localparam logic             PTR_SEL_RESET  = 1'b0;
  localparam logic [ADDR_W-1:0] PTR_RESET     = 16'h0000;
  localparam logic [DATA_W-1:0] READ_ZERO     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: states per machine cycle and the shortest external move.
  localparam int         STATES_PER_MC = 4;
  localparam logic [3:0] MIN_MOVE_MC   = 4'h2;

  // Clock states inside one machine cycle, in order.
  typedef enum logic [1:0] {
    XDS_C1,
    XDS_C2,
    XDS_C3,
    XDS_C4
  } xds_phase_t;

  ////////////////////////////////////////////////////////////////////////////
  // Core access to the special function registers.
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [SFR_W-1:0]  addr;
    logic [DATA_W-1:0] wdata;
  } xds_sfr_req_t;

  // One external data move request from the instruction decoder.
  typedef struct packed {
    logic              start;
    logic              pointer_form;
    logic              write;
    logic [DATA_W-1:0] index_reg;
    logic [DATA_W-1:0] upper_port;
    logic [DATA_W-1:0] wdata;
  } xds_move_req_t;

  // Address and data presented to external memory.
  typedef struct packed {
    logic              active;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } xds_ext_bus_t;

endpackage : xds_pkg

// ### xds_cycle_timer.sv
// Machine cycle sequencer for the external data move.
// Assumes a free-running core clock; the move may start only at a machine
// cycle boundary, so requests are held by the caller until accepted.
`timescale 1ns/1ps
`default_nettype none

module xds_cycle_timer (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  go,
  input  wire logic [2:0]            stretch,
  output var  xds_pkg::xds_phase_t   phase,
  output var  logic                  busy,
  output var  logic                  done
);

  typedef enum logic {
    XDS_T_IDLE,
    XDS_T_RUN
  } xds_tstate_t;

  xds_pkg::xds_phase_t phase_reg;
  xds_pkg::xds_phase_t phase_next;
  xds_tstate_t         state_reg;
  xds_tstate_t         state_next;
  logic [3:0]          mc_left_reg;
  logic [3:0]          mc_left_next;
  logic                done_reg;
  logic                done_next;

  ////////////////////////////////////////////////////////////////////////////
  // The four clock states roll over forever; a move spans whole machine
  // cycles, so it is taken only in C4 and runs from the next C1.
  always_comb begin
    phase_next   = xds_pkg::xds_phase_t'(phase_reg + 2'h1);
    state_next   = state_reg;
    mc_left_next = mc_left_reg;
    done_next    = 1'b0;
    case (state_reg)
      XDS_T_IDLE: begin
        if (go && phase_reg == xds_pkg::XDS_C4) begin
          state_next   = XDS_T_RUN;
          mc_left_next = xds_pkg::MIN_MOVE_MC + {1'b0, stretch};
        end
      end
      XDS_T_RUN: begin
        if (phase_reg == xds_pkg::XDS_C4) begin
          if (mc_left_reg == 4'h1) begin
            state_next = XDS_T_IDLE;
            done_next  = 1'b1;
          end
          mc_left_next = mc_left_reg - 4'h1;
        end
      end
      default: begin
        state_next = XDS_T_IDLE;
      end
    endcase
  end

  // Register stage of the sequencer.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_reg   <= xds_pkg::XDS_C1;
      state_reg   <= XDS_T_IDLE;
      mc_left_reg <= 4'h0;
      done_reg    <= 1'b0;
    end else begin
      phase_reg   <= phase_next;
      state_reg   <= state_next;
      mc_left_reg <= mc_left_next;
      done_reg    <= done_next;
    end
  end

  assign phase = phase_reg;
  assign busy  = (state_reg == XDS_T_RUN);
  assign done  = done_reg;

endmodule : xds_cycle_timer

`default_nettype wire

// ### xds_addr_select.sv
// External data address select: two data pointers, the pointer select
// register, the stretch field and address formation for external moves.
// Assumes the core presents register accesses and move requests as
// one-cycle pulses synchronous to clk, and supplies the indexed working
// register and the upper-address port register with each move request.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - External moves read or write external data space.
// - Indirect form: low byte from index register.
// - Indirect form: high byte from upper port.
// - Pointer form: full selected pointer is address.
// - Two pointers, select bit 0 at 86h.
// - Other select bits ignored, read as zero.
// - Select 0 primary, select 1 secondary.
// - Incrementing select register toggles pointer.
// - Machine cycle is four states C1 to C4.
// - Stretch field sets move length, default 1.
module xds_addr_select (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire xds_pkg::xds_sfr_req_t       sfr_req,
  output var  logic [xds_pkg::DATA_W-1:0]  sfr_rdata,
  input  wire logic                        pointer_inc,
  input  wire xds_pkg::xds_move_req_t      move_req,
  output var  xds_pkg::xds_ext_bus_t       ext_bus,
  input  wire logic [xds_pkg::DATA_W-1:0]  ext_rdata,
  output var  logic [xds_pkg::DATA_W-1:0]  move_rdata,
  output var  logic                        move_busy,
  output var  logic                        move_done
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  logic                       pointer_select_reg;
  logic                       pointer_select_next;
  logic [xds_pkg::ADDR_W-1:0] primary_data_pointer_reg;
  logic [xds_pkg::ADDR_W-1:0] primary_data_pointer_next;
  logic [xds_pkg::ADDR_W-1:0] secondary_data_pointer_reg;
  logic [xds_pkg::ADDR_W-1:0] secondary_data_pointer_next;
  logic [2:0]                 stretch_field_reg;
  logic [2:0]                 stretch_field_next;
  logic [xds_pkg::DATA_W-1:0] sfr_rdata_reg;
  logic [xds_pkg::DATA_W-1:0] sfr_rdata_next;

  xds_pkg::xds_ext_bus_t      ext_bus_reg;
  xds_pkg::xds_ext_bus_t      ext_bus_next;
  logic                       pending_reg;
  logic                       pending_next;
  logic [xds_pkg::DATA_W-1:0] move_rdata_reg;
  logic [xds_pkg::DATA_W-1:0] move_rdata_next;
  logic                       move_done_reg;
  logic                       move_done_next;

  logic                       timer_busy;
  logic                       timer_done;

  ////////////////////////////////////////////////////////////////////////////
  // Picks the pointer that the select bit names; used for register reads,
  // increments and address formation alike.
  function automatic logic [xds_pkg::ADDR_W-1:0] selected_pointer(
    input logic                       sel,
    input logic [xds_pkg::ADDR_W-1:0] primary,
    input logic [xds_pkg::ADDR_W-1:0] secondary
  );
    selected_pointer = sel ? secondary : primary;
  endfunction : selected_pointer

  ////////////////////////////////////////////////////////////////////////////
  // Register file. A pointer byte write and an increment in the same cycle
  // resolve in favour of the write, since software asked for that value.
  always_comb begin
    logic [xds_pkg::ADDR_W-1:0] cur;
    logic [xds_pkg::ADDR_W-1:0] upd;
    cur = selected_pointer(pointer_select_reg, primary_data_pointer_reg,
                           secondary_data_pointer_reg);
    upd = cur;
    pointer_select_next         = pointer_select_reg;
    stretch_field_next          = stretch_field_reg;
    primary_data_pointer_next   = primary_data_pointer_reg;
    secondary_data_pointer_next = secondary_data_pointer_reg;

    if (pointer_inc) begin
      upd = cur + 16'h0001;
    end
    if (sfr_req.wr) begin
      case (sfr_req.addr)
        xds_pkg::PTR_SEL_ADDR: begin
          // Only bit 0 is stored, so an increment of the whole register
          // flips the selection in one instruction.
          pointer_select_next = sfr_req.wdata[xds_pkg::PTR_SEL_BIT];
        end
        xds_pkg::PTR_LOW_ADDR: begin
          upd = {cur[15:8], sfr_req.wdata};
        end
        xds_pkg::PTR_HIGH_ADDR: begin
          upd = {sfr_req.wdata, cur[7:0]};
        end
        xds_pkg::CLK_CTRL_ADDR: begin
          stretch_field_next =
            sfr_req.wdata[xds_pkg::STRETCH_LSB +: xds_pkg::STRETCH_W];
        end
        default: begin
          upd = cur;
        end
      endcase
    end

    // Only the selected pointer takes the new value; the other is held.
    if (pointer_select_reg) begin
      secondary_data_pointer_next = upd;
    end else begin
      primary_data_pointer_next = upd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is registered; unmapped addresses read as zero.
  always_comb begin
    logic [xds_pkg::ADDR_W-1:0] cur;
    cur = selected_pointer(pointer_select_reg, primary_data_pointer_reg,
                           secondary_data_pointer_reg);
    sfr_rdata_next = sfr_rdata_reg;
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        xds_pkg::PTR_SEL_ADDR: begin
          sfr_rdata_next = {7'h00, pointer_select_reg};
        end
        xds_pkg::PTR_LOW_ADDR: begin
          sfr_rdata_next = cur[7:0];
        end
        xds_pkg::PTR_HIGH_ADDR: begin
          sfr_rdata_next = cur[15:8];
        end
        xds_pkg::CLK_CTRL_ADDR: begin
          sfr_rdata_next = {5'h00, stretch_field_reg};
        end
        default: begin
          sfr_rdata_next = xds_pkg::READ_ZERO;
        end
      endcase
    end
  end

  // Register stage of the register file.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pointer_select_reg         <= xds_pkg::PTR_SEL_RESET;
      primary_data_pointer_reg   <= xds_pkg::PTR_RESET;
      secondary_data_pointer_reg <= xds_pkg::PTR_RESET;
      stretch_field_reg          <= xds_pkg::STRETCH_RESET;
      sfr_rdata_reg              <= xds_pkg::READ_ZERO;
    end else begin
      pointer_select_reg         <= pointer_select_next;
      primary_data_pointer_reg   <= primary_data_pointer_next;
      secondary_data_pointer_reg <= secondary_data_pointer_next;
      stretch_field_reg          <= stretch_field_next;
      sfr_rdata_reg              <= sfr_rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle timing for the move.
  xds_cycle_timer u_timer (
    .clk     (clk),
    .resetn  (resetn),
    .go      (pending_reg),
    .stretch (stretch_field_reg),
    .phase   (),
    .busy    (timer_busy),
    .done    (timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // External move. The address is frozen when the request is taken, so a
  // pointer update issued during the move cannot disturb the access.
  // Requests made while a move is in flight are dropped.
  always_comb begin
    ext_bus_next    = ext_bus_reg;
    pending_next    = pending_reg;
    move_rdata_next = move_rdata_reg;
    move_done_next  = 1'b0;

    if (move_req.start && !ext_bus_reg.active) begin
      ext_bus_next.active = 1'b1;
      ext_bus_next.write  = move_req.write;
      ext_bus_next.wdata  = move_req.wdata;
      pending_next        = 1'b1;
      if (move_req.pointer_form) begin
        ext_bus_next.addr = selected_pointer(pointer_select_reg,
                                             primary_data_pointer_reg,
                                             secondary_data_pointer_reg);
      end else begin
        ext_bus_next.addr[7:0]  = move_req.index_reg;
        ext_bus_next.addr[15:8] = move_req.upper_port;
      end
    end

    // The timer has taken the request once it reports busy.
    if (timer_busy) begin
      pending_next = 1'b0;
    end

    if (timer_done && ext_bus_reg.active) begin
      ext_bus_next.active = 1'b0;
      move_done_next      = 1'b1;
      if (!ext_bus_reg.write) begin
        move_rdata_next = ext_rdata;
      end
    end
  end

  // Register stage of the move path.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ext_bus_reg    <= '0;
      pending_reg    <= 1'b0;
      move_rdata_reg <= xds_pkg::READ_ZERO;
      move_done_reg  <= 1'b0;
    end else begin
      ext_bus_reg    <= ext_bus_next;
      pending_reg    <= pending_next;
      move_rdata_reg <= move_rdata_next;
      move_done_reg  <= move_done_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from flip-flops.
  assign sfr_rdata  = sfr_rdata_reg;
  assign ext_bus    = ext_bus_reg;
  assign move_rdata = move_rdata_reg;
  assign move_busy  = ext_bus_reg.active;
  assign move_done  = move_done_reg;

endmodule : xds_addr_select

`default_nettype wire

// ### xds_assertions.sv
// Checker for the external data address select block.
// Sees only the top module's ports and is attached by the bind below.
`timescale 1ns/1ps
`default_nettype none
module xds_addr_select_chk (
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire xds_pkg::xds_sfr_req_t      sfr_req,
  input wire logic [xds_pkg::DATA_W-1:0] sfr_rdata,
  input wire logic                       pointer_inc,
  input wire xds_pkg::xds_move_req_t     move_req,
  input wire xds_pkg::xds_ext_bus_t      ext_bus,
  input wire logic [xds_pkg::DATA_W-1:0] ext_rdata,
  input wire logic [xds_pkg::DATA_W-1:0] move_rdata,
  input wire logic                       move_busy,
  input wire logic                       move_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  // An accepted request, then a busy span of 2 to 9 machine cycles.
  sequence move_taken;
    move_req.start && !move_busy;
  endsequence
  sequence move_span;
    move_busy [*8] ##[3:34] move_done;
  endsequence
  // Busy mirrors the bus and the done pulse closes it.
  busy_tracks_a: assert property (move_busy == ext_bus.active)
    else $error("busy differs from bus active");
  move_length_a: assert property (move_taken |=> move_span)
    else $error("move length out of range");
  done_single_a: assert property (move_done |=> !move_done)
    else $error("done longer than one cycle");
  done_ends_a: assert property (move_done |->
    !move_busy && $past(move_busy))
    else $error("done without a finished move");
  // Address and data captured from the accepted request.
  indirect_addr_a: assert property ((move_taken and
    !move_req.pointer_form) |=> ext_bus.addr == {$past(move_req.upper_port),
    $past(move_req.index_reg)}) else $error("indirect address wrong");
  write_fields_a: assert property (move_taken |=>
    ext_bus.write == $past(move_req.write) &&
    ext_bus.wdata == $past(move_req.wdata)) else $error("fields wrong");
  bus_hold_a: assert property (move_busy && $past(move_busy)
    |-> $stable(ext_bus)) else $error("bus changed during move");
  read_result_a: assert property (move_done && !$past(ext_bus.write)
    |-> move_rdata == $past(ext_rdata)) else $error("read data wrong");
  sel_zero_a: assert property ($past(sfr_req.rd) &&
    $past(sfr_req.addr) == xds_pkg::PTR_SEL_ADDR |-> sfr_rdata[7:1] == 7'h00)
    else $error("select upper bits not zero");
endmodule : xds_addr_select_chk
bind xds_addr_select xds_addr_select_chk xds_addr_select_chk_inst (.clk,
  .resetn, .sfr_req, .sfr_rdata, .pointer_inc, .move_req, .ext_bus,
  .ext_rdata, .move_rdata, .move_busy, .move_done);
`default_nettype wire

// ### xds_ext_mem.sv
// Model of the external data memory on the far side of the block.
// Assumes the bus fields are held for the whole access.
`timescale 1ns/1ps
`default_nettype none
module xds_ext_mem (
  input  wire logic                  clk,
  input  wire xds_pkg::xds_ext_bus_t ext_bus,
  output var  logic [7:0]            ext_rdata = 8'h3C,
  output var  logic [15:0]           wr_addr,
  output var  logic [7:0]            wr_data
);
  // A released bus shows a toggling pattern, so a stale sample fails.
  always_ff @(posedge clk) begin
    if (ext_bus.active && !ext_bus.write) begin
      ext_rdata <= ext_bus.addr[7:0] ^ ext_bus.addr[15:8] ^ 8'hA5;
    end else begin
      ext_rdata <= ~ext_rdata;
    end
    if (ext_bus.active && ext_bus.write) begin
      wr_addr <= ext_bus.addr;
      wr_data <= ext_bus.wdata;
    end
  end
endmodule : xds_ext_mem
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the external data address select block.
// Assumes the checker is bound in and the memory model answers reads.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  clk = 1'b0;
  logic                  resetn = 1'b0;
  logic                  pointer_inc = 1'b0;
  xds_pkg::xds_sfr_req_t  sfr_req = '0;
  xds_pkg::xds_move_req_t move_req = '0;
  xds_pkg::xds_ext_bus_t  ext_bus;
  logic [7:0]            sfr_rdata, ext_rdata, move_rdata, wr_data, d;
  logic [15:0]           wr_addr, p0, p1, q;
  logic                  move_busy, move_done;
  int                    fail_count = 0;
  int                    checks_done = 0;
  int                    cyc = 0;
  always #2.5 clk = ~clk;
  xds_addr_select xds_addr_select_inst (.clk, .resetn, .sfr_req, .sfr_rdata,
    .pointer_inc, .move_req, .ext_bus, .ext_rdata, .move_rdata, .move_busy,
    .move_done);
  xds_ext_mem xds_ext_mem_inst (.clk, .ext_bus, .ext_rdata, .wr_addr,
    .wr_data);
  ////////////////////////////////////////////////////////////////////////
  // Verdict, counts and the hang guard share one exit.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] s, e, input string m);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask : check
  // Expected memory contents for an address.
  function automatic logic [7:0] mem_fn(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction : mem_fn
  ////////////////////////////////////////////////////////////////////////
  // Register and pulse drivers: one cycle per strobe, changed after edges.
  task automatic do_reset();
    resetn = 1'b0;
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
  endtask : do_reset
  task automatic sfr_acc(input logic w, input logic [7:0] a, wd);
    @(posedge clk); #1;
    sfr_req = '{wr: w, rd: !w, addr: a, wdata: wd};
    @(posedge clk); #1;
    sfr_req = '0;
    d = sfr_rdata;
  endtask : sfr_acc
  task automatic rd_ptr(output logic [15:0] v);
    sfr_acc(1'b0, xds_pkg::PTR_LOW_ADDR, 8'h00);
    v[7:0] = d;
    sfr_acc(1'b0, xds_pkg::PTR_HIGH_ADDR, 8'h00);
    v[15:8] = d;
  endtask : rd_ptr
  task automatic wr_ptr(input logic sel, input logic [15:0] v);
    sfr_acc(1'b1, xds_pkg::PTR_SEL_ADDR, {7'h00, sel});
    sfr_acc(1'b1, xds_pkg::PTR_LOW_ADDR, v[7:0]);
    sfr_acc(1'b1, xds_pkg::PTR_HIGH_ADDR, v[15:8]);
  endtask : wr_ptr
  // One move, with a second request poked in that must be refused.
  task automatic do_move(input logic pf, wr, input logic [7:0] i, u, w,
                         input int s, input logic [15:0] ea);
    int n;
    @(posedge clk); #1;
    move_req = '{1'b1, pf, wr, i, u, w};
    @(posedge clk); #1;
    move_req = '{1'b1, !pf, !wr, ~i, ~u, ~w};
    @(posedge clk); #1;
    move_req.start = 1'b0;
    n = 2;
    while (move_done !== 1'b1 && n < 60) begin
      @(posedge clk); #1;
      n++;
    end
    check(16'(n >= 4 * (2 + s) + 3 && n <= 4 * (2 + s) + 6), 16'h1,
          "move length");
    if (wr) begin
      check(wr_addr, ea, "write address");
      check({8'h00, wr_data}, {8'h00, w}, "write data");
    end else begin
      check({8'h00, move_rdata}, {8'h00, mem_fn(ea)}, "read data");
    end
  endtask : do_move
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(15078));
    do_reset();
    sfr_acc(1'b1, xds_pkg::PTR_SEL_ADDR, 8'hFF);
    sfr_acc(1'b0, xds_pkg::PTR_SEL_ADDR, 8'h00);
    check(d, 8'h01, "select store");
    wr_ptr(1'b1, 16'(8'hAB));
    sfr_acc(1'b1, xds_pkg::CLK_CTRL_ADDR, 8'h07);
    do_reset();
    sfr_acc(1'b0, xds_pkg::PTR_SEL_ADDR, 8'h00);
    check(d, 8'h00, "select reset");
    rd_ptr(q);
    check(q, 16'h0000, "pointer reset");
    // The secondary held a written value before the reset, so it must clear.
    sfr_acc(1'b1, xds_pkg::PTR_SEL_ADDR, 8'h01);
    rd_ptr(q);
    check(q, 16'h0000, "secondary reset");
    sfr_acc(1'b0, xds_pkg::CLK_CTRL_ADDR, 8'h00);
    check(d, 8'h01, "stretch reset");
    sfr_acc(1'b0, 8'h90, 8'h00);
    check(d, 8'h00, "unmapped read");
    $display("test reset done");
    p0 = 16'($urandom());
    p1 = 16'hFFFF;
    wr_ptr(1'b0, p0);
    wr_ptr(1'b1, p1);
    rd_ptr(q);
    check(q, p1, "secondary");
    @(posedge clk); #1 pointer_inc = 1'b1;
    @(posedge clk); #1 pointer_inc = 1'b0;
    p1 = 16'h0000;
    rd_ptr(q);
    check(q, p1, "increment wrap");
    for (int k = 0; k < 3; k++) begin
      sfr_acc(1'b0, xds_pkg::PTR_SEL_ADDR, 8'h00);
      sfr_acc(1'b1, xds_pkg::PTR_SEL_ADDR, d + 8'h01);
      rd_ptr(q);
      check(q, k[0] ? p1 : p0, "toggle by increment");
    end
    $display("test pointers done");
    for (int s = 0; s < 8; s++) begin
      logic [7:0] i, u, w;
      i = 8'($urandom());
      u = 8'($urandom());
      w = 8'($urandom());
      sfr_acc(1'b1, xds_pkg::CLK_CTRL_ADDR, 8'(s));
      do_move(1'b0, s[1], i, u, w, s, {u, i});
      sfr_acc(1'b1, xds_pkg::PTR_SEL_ADDR, {7'h00, s[0]});
      do_move(1'b1, !s[1], i, u, w, s, s[0] ? p1 : p0);
    end
    $display("test moves done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
